// *** verilog/dual_slope_adc_sequencer_display.sv ***
// Digital control of a dual-slope converter: sequencer, reading latch, display drive.
// Assumes the comparator and control inputs are synchronous to the oscillator clock.
`timescale 1ns/1ps

module dual_slope_adc_sequencer_display
	import adc_seq_pkg::*;
#(
	parameter bit LCD_VARIANT = 1'b1
) (
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// Analog front end
	input  wire logic   integ_positive_i,
	output phase_e      phase_o,
	output logic        ref_negative_o,
	// Front panel controls
	input  wire logic   reading_hold_input_i,
	input  wire logic   lamp_test_i,
	// Display
	output seg_s        seg_o,
	output logic        backplane_drive_o,
	output logic        over_range_o
);

	// ****************************************
	// Seven-segment decode
	// ****************************************
	function automatic logic [6:0] seven_seg(input logic [3:0] d);
		logic [6:0] s;
		s = SEG_NONE;
		case (d)
			4'h0: s = 7'h3f;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5b;
			4'h3: s = 7'h4f;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6d;
			4'h6: s = 7'h7d;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7f;
			4'h9: s = 7'h6f;
			default: s = SEG_NONE;
		endcase
		return s;
	endfunction

	// ****************************************
	// Count clock prescaler
	// ****************************************
	logic [1:0] pre_q;
	logic [1:0] pre_d;
	logic       tick;

	// The count clock is an enable, not a derived clock, so all logic stays on one edge
	assign tick  = (pre_q == PRE_LAST);
	assign pre_d = tick ? PRE_RST : pre_q + 2'h1;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q <= PRE_RST;
		end else begin
			pre_q <= pre_d;
		end
	end

	// ****************************************
	// Measure cycle position
	// ****************************************
	// A single count of the whole cycle fixes the period no matter where
	// de-integrate stops, so auto-zero simply runs out the remainder.
	logic [11:0] cycle_q;
	logic [11:0] cycle_d;
	logic        cycle_end;
	logic        integ_end;

	assign cycle_end = tick && (cycle_q == CYCLE_LAST);
	assign integ_end = tick && (cycle_q == INTEG_LAST);
	assign cycle_d   = cycle_end ? CYCLE_RST : (tick ? cycle_q + 12'h001 : cycle_q);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cycle_q <= CYCLE_RST;
		end else begin
			cycle_q <= cycle_d;
		end
	end

	// ****************************************
	// De-integrate decade counters
	// ****************************************
	// Digits only step on de-integrate ticks; two bits suffice for the
	// thousands place, since 2000 is the top reading
	logic [3:0] dec_q [3];
	logic [3:0] dec_d [3];
	logic [3:0] carry;
	logic [1:0] thou_q;
	logic [1:0] thou_d;
	logic       count_en;
	logic       count_clr;

	assign carry[0] = count_en;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_decade
			assign carry[i+1] = carry[i] && (dec_q[i] == DIGIT_NINE);
			assign dec_d[i]   = count_clr ? DIGIT_RST :
				(carry[i] ? ((dec_q[i] == DIGIT_NINE) ? DIGIT_ZERO : dec_q[i] + 4'h1) :
				dec_q[i]);

			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					dec_q[i] <= DIGIT_RST;
				end else begin
					dec_q[i] <= dec_d[i];
				end
			end
		end
	endgenerate

	assign thou_d = count_clr ? THOU_RST : (carry[3] ? thou_q + 2'h1 : thou_q);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			thou_q <= THOU_RST;
		end else begin
			thou_q <= thou_d;
		end
	end

	// ****************************************
	// Phase sequencer
	// ****************************************
	phase_e phase_q;
	phase_e phase_d;
	logic   neg_q;
	logic   neg_d;
	logic   crossed;
	logic   at_full;
	logic   deint_end;
	logic   over_now;
	logic   in_deint;

	assign in_deint  = (phase_q == PH_DEINTEGRATE);
	// Zero crossing: integrator has swung back past the sampled polarity
	assign crossed   = (integ_positive_i == neg_q);
	// Count 1999 on a non-crossing tick steps to 2000, the full-scale limit;
	// the decade carry is left out, since it rises on that very tick
	assign at_full   = (thou_q == THOU_FULL - 2'h1)
		&& (dec_q[0] == DIGIT_NINE)
		&& (dec_q[1] == DIGIT_NINE)
		&& (dec_q[2] == DIGIT_NINE);
	assign deint_end = in_deint && tick && (crossed || at_full);
	// A crossing on the last tick wins, so exactly full scale is not over-range
	assign over_now  = deint_end && !crossed;
	assign count_en  = in_deint && tick && !crossed;
	assign count_clr = integ_end;

	always_comb begin
		phase_d = phase_q;
		neg_d   = neg_q;
		case (phase_q)
			PH_INTEGRATE: begin
				if (integ_end) begin
					// Negative input leaves the integrator below zero
					neg_d   = !integ_positive_i;
					phase_d = PH_DEINTEGRATE;
				end
			end
			PH_DEINTEGRATE: begin
				if (deint_end) begin
					phase_d = PH_AUTO_ZERO;
				end
			end
			PH_AUTO_ZERO: begin
				if (cycle_end) begin
					phase_d = PH_INTEGRATE;
				end
			end
			default: phase_d = PH_INTEGRATE;
		endcase
	end

	// Reset starts a fresh cycle at the head of signal integrate
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_q <= PH_INTEGRATE;
			neg_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			neg_q   <= neg_d;
		end
	end

	// ****************************************
	// Reading latch
	// ****************************************
	reading_s rd_q;
	reading_s rd_d;
	logic     load;

	// Hold only stops the load; counters and phases run on, so the cycle
	// length never depends on hold
	assign load = deint_end && !reading_hold_input_i;

	always_comb begin
		rd_d = rd_q;
		if (load) begin
			rd_d.minus = neg_q;
			rd_d.over  = over_now;
			rd_d.thou  = thou_q;
			rd_d.hund  = dec_q[2];
			rd_d.tens  = dec_q[1];
			rd_d.units = dec_q[0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

	// ****************************************
	// Backplane divider
	// ****************************************
	logic [8:0] bp_cnt_q;
	logic [8:0] bp_cnt_d;
	logic       bp_q;
	logic       bp_d;
	logic       bp_flip;

	// The divider also runs in the LED build; only its output is cut
	assign bp_flip  = (bp_cnt_q == BP_LAST);
	assign bp_cnt_d = bp_flip ? BP_RST : bp_cnt_q + 9'h001;
	assign bp_d     = LCD_VARIANT ? (bp_q ^ bp_flip) : 1'b0;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bp_cnt_q <= BP_RST;
			bp_q     <= 1'b0;
		end else begin
			bp_cnt_q <= bp_cnt_d;
			bp_q     <= bp_d;
		end
	end

	// ****************************************
	// Segment drive
	// ****************************************
	seg_s lit;
	seg_s seg_d;

	// Segments decode the latch's next value, so digits, sign and the
	// over-range flag all change on the same edge
	// Lamp test keeps the square wave on LCD, so no DC stands on the glass
	assign lit = lamp_test_i ? seg_s'('1) :
		rd_d.over ? seg_s'{minus: rd_d.minus, thou_one: 1'b1,
			hund: SEG_NONE, tens: SEG_NONE, units: SEG_NONE} :
		seg_s'{minus: rd_d.minus, thou_one: (rd_d.thou != THOU_RST),
			hund: seven_seg(rd_d.hund), tens: seven_seg(rd_d.tens),
			units: seven_seg(rd_d.units)};

	// Next backplane level used so segments and backplane switch together
	assign seg_d = LCD_VARIANT ? (lit ^ {$bits(seg_s){bp_d}}) : lit;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seg_o             <= '0;
			backplane_drive_o <= 1'b0;
			phase_o           <= PH_INTEGRATE;
			ref_negative_o    <= 1'b0;
			over_range_o      <= 1'b0;
		end else begin
			seg_o             <= seg_d;
			backplane_drive_o <= bp_d;
			phase_o           <= phase_d;
			ref_negative_o    <= neg_d;
			over_range_o      <= rd_d.over;
		end
	end

endmodule

// *** verilog/adc_seq_pkg.sv ***
// Constants and types shared by the dual-slope converter sequencer.
// Assumes one free-running oscillator clock drives all of the logic.
package adc_seq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned OSC_DIV      = 4;     // Oscillator clocks per count
	localparam int unsigned INTEG_COUNTS = 1000;  // Signal integrate length
	localparam int unsigned DEINT_MAX    = 2000;  // Longest de-integrate, full scale
	localparam int unsigned CYCLE_COUNTS = 4000;  // Whole measure cycle
	localparam int unsigned BP_DIV       = 800;   // Oscillator clocks per backplane period
	localparam int unsigned BP_HALF      = BP_DIV / 2;

	localparam logic [1:0]  PRE_LAST   = 2'(OSC_DIV - 1);
	localparam logic [11:0] INTEG_LAST = 12'(INTEG_COUNTS - 1);
	localparam logic [11:0] CYCLE_LAST = 12'(CYCLE_COUNTS - 1);
	localparam logic [8:0]  BP_LAST    = 9'(BP_HALF - 1);

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0]  PRE_RST   = 2'h0;
	localparam logic [11:0] CYCLE_RST = 12'h000;
	localparam logic [8:0]  BP_RST    = 9'h000;
	localparam logic [3:0]  DIGIT_RST = 4'h0;
	localparam logic [1:0]  THOU_RST  = 2'h0;

	// ****************************************
	// Digit values
	// ****************************************
	localparam logic [3:0] DIGIT_NINE = 4'h9;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [1:0] THOU_FULL  = 2'(DEINT_MAX / 1000);
	localparam logic [6:0] SEG_ALL    = 7'h7f;
	localparam logic [6:0] SEG_NONE   = 7'h00;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PH_INTEGRATE,
		PH_DEINTEGRATE,
		PH_AUTO_ZERO
	} phase_e;

	// Latched reading: sign, thousands, and three decades
	typedef struct packed {
		logic       minus;
		logic       over;
		logic [1:0] thou;
		logic [3:0] hund;
		logic [3:0] tens;
		logic [3:0] units;
	} reading_s;

	// Segment drive, each digit gfedcba
	typedef struct packed {
		logic       minus;
		logic       thou_one;
		logic [6:0] hund;
		logic [6:0] tens;
		logic [6:0] units;
	} seg_s;

endpackage

// *** tb/display_panel.sv ***
// Model of the seven-segment panel on the far side of the segment drive.
// Assumes segment and backplane outputs come straight from the converter.
`timescale 1ns/1ps

module display_panel
	import adc_seq_pkg::*;
#(
	parameter bit LCD_VARIANT = 1'b1
) (
	// Drive from the converter
	input  wire seg_s  seg_i,
	input  wire logic  backplane_i,
	// Segments that glow
	output seg_s       lit_o
);
	// ********
	// Decode
	// ********
	// A liquid crystal shows a segment only while it opposes the backplane
	assign lit_o = LCD_VARIANT ? seg_s'(seg_i ^ {23{backplane_i}}) : seg_i;
endmodule

// *** tb/adc_seq_checker_sva.sv ***
// Concurrent checks on the sequencer and display ports.
// Assumes the bind below and one oscillator clock.
`timescale 1ns/1ps

module adc_seq_checker
	import adc_seq_pkg::*;
#(
	parameter bit LCD_VARIANT = 1'b1
) (
	input wire logic   clk_i,
	input wire logic   rst_i,
	input phase_e      phase_o,
	input wire logic   reading_hold_input_i,
	input wire logic   lamp_test_i,
	input seg_s        seg_o,
	input wire logic   backplane_drive_o,
	input wire logic   over_range_o
);
	// ********
	// Run lengths
	// ********
	logic [13:0] run_q;
	logic [13:0] dlen_q;
	logic [8:0]  bprun_q;
	phase_e      prev_q;
	logic        valid_q;
	logic        bpv_q;
	logic        bpp_q;
	seg_s        lit;
	wire         chg = phase_o != prev_q;
	wire         bpc = backplane_drive_o != bpp_q;
	assign lit = seg_s'(seg_o ^ {23{backplane_drive_o}});
	// First integrate and backplane runs after reset are skipped: they include reset time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= PH_INTEGRATE;
			run_q <= 14'h0;
			dlen_q <= 14'h0;
			valid_q <= 1'b0;
			bpp_q <= 1'b0;
			bprun_q <= 9'h0;
			bpv_q <= 1'b0;
		end else begin
			prev_q <= phase_o;
			run_q <= chg ? 14'h1 : run_q + 14'h1;
			dlen_q <= (chg && prev_q == PH_DEINTEGRATE) ? run_q : dlen_q;
			valid_q <= valid_q | chg;
			bpp_q <= backplane_drive_o;
			bprun_q <= bpc ? 9'h1 : bprun_q + 9'h1;
			bpv_q <= bpv_q | bpc;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_integ_len_fixed: assert property (chg && valid_q && prev_q == PH_INTEGRATE |-> run_q == 14'd4000)
		else $error("integrate length wrong");
	a_cycle_len_fixed: assert property (chg && prev_q == PH_AUTO_ZERO |-> dlen_q + run_q == 12000)
		else $error("deintegrate plus auto-zero wrong");
	a_deint_len_bound: assert property (chg && prev_q == PH_DEINTEGRATE |->
		run_q <= 14'd8000 && run_q != 14'h0 && run_q[1:0] == 2'h0)
		else $error("deintegrate length out of range");
	a_bp_half_period: assert property (LCD_VARIANT && bpc && bpv_q |-> bprun_q == 9'd400)
		else $error("backplane half period wrong");
	a_lamp_all_lit: assert property ($past(lamp_test_i) |-> lit == seg_s'('1))
		else $error("lamp test not all lit");
	a_over_blank_low: assert property (over_range_o && !$past(lamp_test_i) |->
		lit.thou_one && lit.hund == 7'h00 && lit.tens == 7'h00 && lit.units == 7'h00)
		else $error("over-range digits not blanked");
	a_over_at_full: assert property (chg && prev_q == PH_DEINTEGRATE && !$past(reading_hold_input_i)
		|-> over_range_o == (run_q == 14'd8000))
		else $error("over-range flag wrong");
	a_hold_keeps_read: assert property (chg && prev_q == PH_DEINTEGRATE && $past(reading_hold_input_i)
		|-> lit == seg_s'($past(seg_o) ^ {23{$past(backplane_drive_o)}}) && $stable(over_range_o))
		else $error("held reading changed");
endmodule

bind dual_slope_adc_sequencer_display adc_seq_checker #(.LCD_VARIANT(LCD_VARIANT)) u_adc_seq_checker (
	.clk_i, .rst_i, .phase_o, .reading_hold_input_i, .lamp_test_i, .seg_o, .backplane_drive_o,
	.over_range_o);

// *** tb/test_dual_slope_adc_sequencer_display.sv ***
// Testbench: LCD and LED builds side by side, comparator modelled by tick count.
// Assumes ticks on every 4th edge after reset release.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end

module test_dual_slope_adc_sequencer_display
	import adc_seq_pkg::*;
;
	logic   clk_i = 1'b0;
	logic   rst_i = 1'b1;
	logic   integ_positive_i = 1'b1;
	logic   reading_hold_input_i = 1'b0;
	logic   lamp_test_i = 1'b0;
	phase_e phase_o;
	logic   ref_negative_o;
	logic   backplane_drive_o;
	logic   over_range_o;
	logic   bp_led;
	logic   ov_q = 1'b0;
	seg_s   seg_o;
	seg_s   seg_led;
	seg_s   lit;
	seg_s   exp_q;
	int     edge_n = 0;
	int     error_cnt = 0;
	int     total_checks = 0;
	localparam logic [6:0] SEG7 [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
		7'h7f, 7'h6f};

	dual_slope_adc_sequencer_display #(.LCD_VARIANT(1'b1)) u_dual_slope_adc_sequencer_display (
		.clk_i, .rst_i, .integ_positive_i, .phase_o, .ref_negative_o, .reading_hold_input_i,
		.lamp_test_i, .seg_o, .backplane_drive_o, .over_range_o);
	dual_slope_adc_sequencer_display #(.LCD_VARIANT(1'b0)) u_dual_slope_adc_sequencer_display_led (
		.clk_i, .rst_i, .integ_positive_i, .phase_o(), .ref_negative_o(), .reading_hold_input_i,
		.lamp_test_i, .seg_o(seg_led), .backplane_drive_o(bp_led), .over_range_o());
	display_panel #(.LCD_VARIANT(1'b1)) u_display_panel (.seg_i(seg_o), .backplane_i(backplane_drive_o),
		.lit_o(lit));

	// ********
	// Helpers
	// ********
	initial forever #10 clk_i = ~clk_i;
	always @(posedge clk_i) if (!rst_i) edge_n <= edge_n + 1;

	function automatic seg_s exp_read(bit neg, int n, bit ov);
		seg_s e;
		e = '0;
		e.minus = neg;
		e.thou_one = ov || n >= 1000;
		if (!ov) begin
			e.hund = SEG7[(n / 100) % 10];
			e.tens = SEG7[(n / 10) % 10];
			e.units = SEG7[n % 10];
		end
		return e;
	endfunction

	task automatic wait_e(int t);
		while (edge_n < t) begin
			@(posedge clk_i);
			#1;
		end
	endtask

	// Comparator flips just before tick n+1 of de-integrate, giving count n
	task automatic run_cycle(int c, bit neg, int n, bit ov);
		int b;
		b = 16000 * c;
		wait_e(b);
		integ_positive_i = !neg;
		wait_e(b + 4000 + 4 * n);
		integ_positive_i = ov ? !neg : neg;
		wait_e(b + 12010);
		`CHK(phase_o, PH_AUTO_ZERO)
		`CHK(ref_negative_o, neg)
		`CHK(lit, exp_q)
		`CHK(seg_led, exp_q)
		`CHK(bp_led, 1'b0)
		`CHK(over_range_o, ov_q)
	endtask

	task automatic end_sim;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_positive;
		exp_q = exp_read(1'b0, 1789, 1'b0);
		run_cycle(0, 1'b0, 1789, 1'b0);
		$display("test positive done");
	endtask

	task automatic t_neg_zero;
		exp_q = exp_read(1'b1, 0, 1'b0);
		run_cycle(1, 1'b1, 0, 1'b0);
		$display("test negative zero done");
	endtask

	task automatic t_over;
		exp_q = exp_read(1'b1, 2000, 1'b1);
		ov_q = 1'b1;
		run_cycle(2, 1'b1, 2000, 1'b1);
		$display("test over-range done");
	endtask

	// Held cycle must leave the over-range reading in place
	task automatic t_hold;
		reading_hold_input_i = 1'b1;
		run_cycle(3, 1'b0, 123, 1'b0);
		reading_hold_input_i = 1'b0;
		exp_q = exp_read(1'b0, 456, 1'b0);
		ov_q = 1'b0;
		run_cycle(4, 1'b0, 456, 1'b0);
		$display("test hold done");
	endtask

	task automatic t_lamp;
		lamp_test_i = 1'b1;
		wait_e(edge_n + 2);
		`CHK(lit, seg_s'('1))
		`CHK(seg_led, seg_s'('1))
		lamp_test_i = 1'b0;
		wait_e(edge_n + 2);
		`CHK(lit, exp_q)
		$display("test lamp done");
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		t_positive();
		t_neg_zero();
		t_over();
		t_hold();
		t_lamp();
		end_sim();
	end

	initial begin
		#1800000;
		error_cnt++;
		end_sim();
	end
endmodule
